// ==== rtl/sfwp_consts.vh ====
// Constants of the serial flash write protection block
`ifndef SFWP_CONSTS_VH
`define SFWP_CONSTS_VH
`define SFWP_CMD_LATCH_SET 8'h06
`define SFWP_CMD_LATCH_CLR 8'h04
`define SFWP_CMD_STATUS_WR 8'h01
`define SFWP_CMD_PAGE_PROG 8'h02
`define SFWP_CMD_SECTOR_ERASE 8'h20
`define SFWP_CMD_BLOCK32_ERASE 8'h52
`define SFWP_CMD_BLOCK64_ERASE 8'hD8
`define SFWP_CMD_CHIP_ERASE_A 8'hC7
`define SFWP_CMD_CHIP_ERASE_B 8'h60
`define SFWP_CMD_SEC_PROG 8'h42
`define SFWP_CMD_SEC_ERASE 8'h44
`define SFWP_CMD_DEEP_PD 8'hB9
`define SFWP_CMD_DEEP_PD_EXIT 8'hAB
`define SFWP_CMD_RESET_ARM 8'h66
`define SFWP_CMD_RESET_GO 8'h99
`define SFWP_BIT_BUSY 0
`define SFWP_BIT_LATCH 1
`define SFWP_BIT_BLK_LO 2
`define SFWP_BIT_BLK_HI 6
`define SFWP_BIT_MODE_LO 7
`define SFWP_BIT_MODE_HI 8
`define SFWP_BIT_QUAD 9
`define SFWP_BIT_SEC_LO 10
`define SFWP_BIT_SEC_HI 11
`define SFWP_BIT_SCHEME 12
`define SFWP_BIT_COMPL 14
`define SFWP_STATUS_RST 16'h0000
`define SFWP_BLK_RST 5'h00
`define SFWP_MODE_RST 2'h0
`define SFWP_SEC_RST 2'h0
`define SFWP_MODE_SOFT 2'h0
`define SFWP_MODE_HW 2'h1
`define SFWP_MODE_LOCKDOWN 2'h2
`define SFWP_MODE_OTP 2'h3
`define SFWP_SPAN_SECTOR 24'h000FFF
`define SFWP_SPAN_BLOCK32 24'h007FFF
`define SFWP_SPAN_BLOCK64 24'h00FFFF
`define SFWP_SPAN_NONE 24'h000000
`define SFWP_ADDR_ALL 24'hFFFFFF
`define SFWP_EXP_SMALL 5'h11
`define SFWP_EXP_TINY 5'h0B
`define SFWP_EXP_TINY_MAX 5'h0F
`define SFWP_SEC_PAGE_HI 13
`define SFWP_SEC_PAGE_LO 12
`endif

// ==== rtl/sfwp_range.v ====
// Decodes block-protect and complement fields into a protected-address test
`timescale 1ns/1ps
`include "sfwp_consts.vh"
module sfwp_range (
    input wire [4:0] blk,
    input wire compl,
    input wire [23:0] addr,
    output reg hit
);
    reg [4:0] expo;
    reg [23:0] mask;
    reg base;
    always @* begin
        expo = 5'h00;
        mask = 24'h000000;
        base = 1'b0;
        if (blk[2:0] == 3'h0) begin
            base = 1'b0;
        end else if (blk[2:0] == 3'h7) begin
            base = 1'b1;
        end else begin
            if (!blk[4]) begin
                expo = `SFWP_EXP_SMALL + {2'h0, blk[2:0]};
            end else if (blk[2]) begin
                expo = `SFWP_EXP_TINY_MAX;
            end else begin
                expo = `SFWP_EXP_TINY + {2'h0, blk[2:0]};
            end
            mask = `SFWP_ADDR_ALL << expo;
            // Bottom region when bit 3 set, top otherwise
            base = blk[3] ? ((addr & mask) == 24'h000000) : ((addr & mask) == mask);
        end
        hit = base ^ compl;
    end
endmodule // sfwp_range

// ==== rtl/sfwp_sr_gate.v ====
// Decides whether a status write may take effect
`timescale 1ns/1ps
`include "sfwp_consts.vh"
module sfwp_sr_gate (
    input wire [1:0] mode,
    input wire wp_n,
    input wire latch,
    input wire hw_lock,
    output reg allow,
    output reg hw_lock_set
);
    always @* begin
        hw_lock_set = (mode == `SFWP_MODE_HW) && !wp_n;
        case (mode)
            `SFWP_MODE_SOFT: allow = latch;
            `SFWP_MODE_HW: allow = latch && wp_n && !hw_lock;
            `SFWP_MODE_LOCKDOWN: allow = 1'b0;
            `SFWP_MODE_OTP: allow = 1'b0;
            default: allow = 1'b0;
        endcase
    end
endmodule // sfwp_sr_gate

// ==== rtl/sfwp_top.v ====
// Write protection, write latch and status register of a serial NOR flash
// Summary of operation
// - Mode 00: status write needs latch only
// - Mode 01, pin low with quad bit clear: locked until power-up
// - Mode 01, pin high: write after latch set
// - Mode 10 locks; power cycle returns 00
// - Mode 11 refuses status writes forever
// - Quad bit turns protect/hold pins into lanes
// - Security lock bits set once, never clear
// - Lock makes pages read-only, others unerasable
// - Complement bit at bit 14, default 0
// - Scheme bit: range protection or block locks
// - Block locks all set after any reset
// - Latch set/clear by listed commands and resets
// - Protected region readable, not programmable/erasable
// - Deep power-down ignores all but exit/reset
// - Small-range codes protect 1/64 to 1/2
// - Bit 4 set protects 4KB to 32KB
// - Complement bit inverts the protected region
// - Chip erase only with all-none/all-all codes
`timescale 1ns/1ps
`include "sfwp_consts.vh"
module sfwp_top (
    input wire clock,
    input wire nrst,
    input wire power_cycle,
    input wire cmd_valid,
    input wire [7:0] cmd_code,
    input wire [23:0] cmd_addr,
    input wire [15:0] cmd_data,
    input wire wp_n,
    input wire hold_n,
    output reg [15:0] status_out,
    output reg cmd_done,
    output reg cmd_refused,
    output reg cmd_ignored,
    output reg op_start,
    output reg [7:0] op_code,
    output reg [23:0] op_addr,
    output reg quad_lane_enable,
    output reg hold_active,
    output reg deep_pd
);
    reg write_latch_flag_reg;
    reg [4:0] blk_reg;
    reg [1:0] mode_reg;
    reg quad_reg;
    reg [1:0] sec_lock_reg;
    reg scheme_reg;
    reg compl_reg;
    reg hw_lock_reg;
    reg lock_all_reg;
    reg dpd_reg;
    reg rst_arm_reg;

    wire prot_first;
    wire prot_last;
    wire sr_allow;
    wire hw_lock_set;
    wire [1:0] sec_page;
    wire [15:0] status_now;
    wire eff_wp_n;

    reg [23:0] span;
    reg is_page_prog;
    reg is_area_erase;
    reg is_chip_erase;
    reg is_sec_prog;
    reg is_sec_erase;
    reg is_write_cmd;
    reg array_prot;
    reg chip_ok;
    reg sec_bad;
    reg write_latch_flag_next;
    reg hw_lock_next;
    reg rst_arm_next;
    reg is_reset_go;

    wire [4:0] wr_blk;
    wire [1:0] wr_mode;
    wire wr_quad;
    wire [1:0] wr_sec;
    wire wr_scheme;
    wire wr_compl;

    // Pin loses its protect role once it carries data
    assign eff_wp_n = quad_reg ? 1'b1 : wp_n;
    assign sec_page = cmd_addr[`SFWP_SEC_PAGE_HI:`SFWP_SEC_PAGE_LO];
    assign status_now = {1'b0, compl_reg, 1'b0, scheme_reg, sec_lock_reg, quad_reg,
        mode_reg, blk_reg, write_latch_flag_reg, 1'b0};

    // Fields of the status write word
    assign wr_blk = cmd_data[`SFWP_BIT_BLK_HI:`SFWP_BIT_BLK_LO];
    assign wr_mode = cmd_data[`SFWP_BIT_MODE_HI:`SFWP_BIT_MODE_LO];
    assign wr_quad = cmd_data[`SFWP_BIT_QUAD];
    assign wr_sec = cmd_data[`SFWP_BIT_SEC_HI:`SFWP_BIT_SEC_LO];
    assign wr_scheme = cmd_data[`SFWP_BIT_SCHEME];
    assign wr_compl = cmd_data[`SFWP_BIT_COMPL];

    // First and last byte of the addressed area; regions are end-anchored
    sfwp_range u_range_first (
        .blk(blk_reg),
        .compl(compl_reg),
        .addr(cmd_addr),
        .hit(prot_first)
    );

    sfwp_range u_range_last (
        .blk(blk_reg),
        .compl(compl_reg),
        .addr(cmd_addr | span),
        .hit(prot_last)
    );

    sfwp_sr_gate u_sr_gate (
        .mode(mode_reg),
        .wp_n(eff_wp_n),
        .latch(write_latch_flag_reg),
        .hw_lock(hw_lock_reg),
        .allow(sr_allow),
        .hw_lock_set(hw_lock_set)
    );

    always @* begin
        span = `SFWP_SPAN_NONE;
        is_page_prog = 1'b0;
        is_area_erase = 1'b0;
        is_chip_erase = 1'b0;
        is_sec_prog = 1'b0;
        is_sec_erase = 1'b0;
        case (cmd_code)
            `SFWP_CMD_PAGE_PROG: is_page_prog = 1'b1;
            `SFWP_CMD_SECTOR_ERASE: begin
                is_area_erase = 1'b1;
                span = `SFWP_SPAN_SECTOR;
            end
            `SFWP_CMD_BLOCK32_ERASE: begin
                is_area_erase = 1'b1;
                span = `SFWP_SPAN_BLOCK32;
            end
            `SFWP_CMD_BLOCK64_ERASE: begin
                is_area_erase = 1'b1;
                span = `SFWP_SPAN_BLOCK64;
            end
            `SFWP_CMD_CHIP_ERASE_A: is_chip_erase = 1'b1;
            `SFWP_CMD_CHIP_ERASE_B: is_chip_erase = 1'b1;
            `SFWP_CMD_SEC_PROG: is_sec_prog = 1'b1;
            `SFWP_CMD_SEC_ERASE: is_sec_erase = 1'b1;
            default: span = `SFWP_SPAN_NONE;
        endcase
        is_write_cmd = is_page_prog | is_area_erase | is_chip_erase | is_sec_prog | is_sec_erase;
        // Block locks replace the range decode when the scheme bit is set
        array_prot = scheme_reg ? lock_all_reg : (prot_first | prot_last);
        if (scheme_reg) begin
            chip_ok = !lock_all_reg;
        end else begin
            chip_ok = ((blk_reg[2:0] == 3'h0) && !compl_reg)
                || ((blk_reg[2:0] == 3'h7) && compl_reg);
        end
        // Own half locked: read-only; any lock: no security erase
        if (is_sec_prog) begin
            sec_bad = sec_lock_reg[sec_page[1]];
        end else begin
            sec_bad = |sec_lock_reg;
        end
    end

    // Latch next value: one set event, many clear events
    always @* begin
        is_reset_go = (cmd_code == `SFWP_CMD_RESET_GO) && rst_arm_reg;
        write_latch_flag_next = write_latch_flag_reg;
        if (power_cycle) begin
            write_latch_flag_next = 1'b0;
        end else if (cmd_valid) begin
            if (is_reset_go) begin
                write_latch_flag_next = 1'b0;
            end else if (dpd_reg) begin
                // Sleeping part keeps its latch
                write_latch_flag_next = write_latch_flag_reg;
            end else if (cmd_code == `SFWP_CMD_LATCH_SET) begin
                write_latch_flag_next = 1'b1;
            end else if (cmd_code == `SFWP_CMD_LATCH_CLR) begin
                write_latch_flag_next = 1'b0;
            end else if ((cmd_code == `SFWP_CMD_STATUS_WR) || is_write_cmd) begin
                write_latch_flag_next = 1'b0;
            end
        end
    end

    // Hardware lock holds until power returns
    always @* begin
        hw_lock_next = hw_lock_reg;
        if (power_cycle) begin
            hw_lock_next = 1'b0;
        end else if (hw_lock_set) begin
            hw_lock_next = 1'b1;
        end
    end

    // Reset pair must come back to back
    always @* begin
        rst_arm_next = rst_arm_reg;
        if (power_cycle) begin
            rst_arm_next = 1'b0;
        end else if (cmd_valid) begin
            rst_arm_next = (cmd_code == `SFWP_CMD_RESET_ARM);
        end
    end

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            write_latch_flag_reg <= 1'b0;
            blk_reg <= `SFWP_BLK_RST;
            mode_reg <= `SFWP_MODE_RST;
            quad_reg <= 1'b0;
            sec_lock_reg <= `SFWP_SEC_RST;
            scheme_reg <= 1'b0;
            compl_reg <= 1'b0;
            hw_lock_reg <= 1'b0;
            lock_all_reg <= 1'b1;
            dpd_reg <= 1'b0;
            rst_arm_reg <= 1'b0;
            status_out <= `SFWP_STATUS_RST;
            cmd_done <= 1'b0;
            cmd_refused <= 1'b0;
            cmd_ignored <= 1'b0;
            op_start <= 1'b0;
            op_code <= 8'h00;
            op_addr <= 24'h000000;
            quad_lane_enable <= 1'b0;
            hold_active <= 1'b0;
            deep_pd <= 1'b0;
        end else begin
            cmd_done <= 1'b0;
            cmd_refused <= 1'b0;
            cmd_ignored <= 1'b0;
            op_start <= 1'b0;
            status_out <= status_now;
            quad_lane_enable <= quad_reg;
            hold_active <= !quad_reg && !hold_n;
            deep_pd <= dpd_reg;
            write_latch_flag_reg <= write_latch_flag_next;
            hw_lock_reg <= hw_lock_next;
            rst_arm_reg <= rst_arm_next;
            if (power_cycle) begin
                // Power-down/up: volatile state back to defaults
                lock_all_reg <= 1'b1;
                dpd_reg <= 1'b0;
                if (mode_reg == `SFWP_MODE_LOCKDOWN) begin
                    mode_reg <= `SFWP_MODE_SOFT;
                end
            end else begin
                if (cmd_valid) begin
                    if (cmd_code == `SFWP_CMD_RESET_ARM) begin
                        cmd_done <= 1'b1;
                    end else if (is_reset_go) begin
                        // Software reset keeps non-volatile bits
                        lock_all_reg <= 1'b1;
                        dpd_reg <= 1'b0;
                        cmd_done <= 1'b1;
                    end else if (dpd_reg) begin
                        if (cmd_code == `SFWP_CMD_DEEP_PD_EXIT) begin
                            dpd_reg <= 1'b0;
                            cmd_done <= 1'b1;
                        end else begin
                            cmd_ignored <= 1'b1;
                        end
                    end else if (cmd_code == `SFWP_CMD_LATCH_SET) begin
                        cmd_done <= 1'b1;
                    end else if (cmd_code == `SFWP_CMD_LATCH_CLR) begin
                        cmd_done <= 1'b1;
                    end else if (cmd_code == `SFWP_CMD_DEEP_PD) begin
                        dpd_reg <= 1'b1;
                        cmd_done <= 1'b1;
                    end else if (cmd_code == `SFWP_CMD_STATUS_WR) begin
                        if (sr_allow) begin
                            blk_reg <= wr_blk;
                            mode_reg <= wr_mode;
                            quad_reg <= wr_quad;
                            // Lock bits only ever accumulate
                            sec_lock_reg <= sec_lock_reg | wr_sec;
                            scheme_reg <= wr_scheme;
                            compl_reg <= wr_compl;
                            cmd_done <= 1'b1;
                        end else begin
                            cmd_refused <= 1'b1;
                        end
                    end else if (is_write_cmd) begin
                        if (!write_latch_flag_reg) begin
                            cmd_refused <= 1'b1;
                        end else if ((is_page_prog || is_area_erase) && array_prot) begin
                            cmd_refused <= 1'b1;
                        end else if (is_chip_erase && !chip_ok) begin
                            cmd_refused <= 1'b1;
                        end else if ((is_sec_prog || is_sec_erase) && sec_bad) begin
                            cmd_refused <= 1'b1;
                        end else begin
                            op_start <= 1'b1;
                            op_code <= cmd_code;
                            op_addr <= cmd_addr;
                            cmd_done <= 1'b1;
                        end
                    end else begin
                        // Reads and other commands pass untouched
                        cmd_done <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // sfwp_top

// ==== sim/sfwp_properties.sv ====
// Port-level assertions for the write protection block
`timescale 1ns/1ps
module sfwp_properties (
    input wire clock,
    input wire nrst,
    input wire power_cycle,
    input wire cmd_valid,
    input wire [7:0] cmd_code,
    input wire [15:0] status_out,
    input wire cmd_done,
    input wire cmd_refused,
    input wire cmd_ignored,
    input wire op_start,
    input wire [7:0] op_code,
    input wire quad_lane_enable,
    input wire hold_active,
    input wire deep_pd
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    wire take = cmd_valid && !power_cycle;
    wire wtype = cmd_code inside {8'h01, 8'h02, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h42, 8'h44};
    sequence s_take(c);
        take && cmd_code == c;
    endsequence
    sequence s_write;
        take && wtype;
    endsequence
    a_one_answer: assert property (take |=> $onehot({cmd_done, cmd_refused, cmd_ignored}))
        else $error("command not answered exactly once");
    a_no_stray: assert property (!take |=> !(cmd_done || cmd_refused || cmd_ignored))
        else $error("answer without a command");
    a_latch_set: assert property (s_take(8'h06) ##1 !deep_pd && !power_cycle |=> status_out[1])
        else $error("write latch not set");
    a_write_clears: assert property (s_write ##1 !deep_pd |=> !status_out[1])
        else $error("write latch not cleared");
    a_need_latch: assert property (s_write |=> !status_out[1] && !deep_pd |-> cmd_refused)
        else $error("write accepted without latch");
    a_mode_lock: assert property (s_take(8'h01) |=> status_out[8] && !deep_pd |-> cmd_refused)
        else $error("status write accepted while locked");
    a_pd_ignore: assert property (take && !(cmd_code inside {8'hAB, 8'h66, 8'h99}) |=>
        deep_pd |-> cmd_ignored) else $error("command not ignored in deep power-down");
    a_chip_guard: assert property (take && (cmd_code == 8'hC7 || cmd_code == 8'h60) |=>
        status_out[4:2] != {3{status_out[14]}} && !deep_pd |-> cmd_refused)
        else $error("chip erase not refused");
    a_launch_ok: assert property (op_start |-> cmd_done && op_code inside {8'h02, 8'h20,
        8'h52, 8'hD8, 8'hC7, 8'h60, 8'h42, 8'h44}) else $error("launch without accepted write");
    a_lock_sticky: assert property (($past(status_out[11:10]) & ~status_out[11:10]) == 2'h0)
        else $error("security lock bit cleared");
    a_quad_pins: assert property (quad_lane_enable && $past(quad_lane_enable) |-> !hold_active)
        else $error("hold active while pins are lanes");
endmodule // sfwp_properties
bind sfwp_top sfwp_properties i_sfwp_properties (.clock(clock), .nrst(nrst),
    .power_cycle(power_cycle), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .status_out(status_out), .cmd_done(cmd_done), .cmd_refused(cmd_refused),
    .cmd_ignored(cmd_ignored), .op_start(op_start), .op_code(op_code),
    .quad_lane_enable(quad_lane_enable), .hold_active(hold_active), .deep_pd(deep_pd));

// ==== sim/sfwp_host.sv ====
// Host controller model issuing decoded commands
`timescale 1ns/1ps
module sfwp_host (
    output reg cmd_valid,
    output reg [7:0] cmd_code,
    output reg [23:0] cmd_addr,
    output reg [15:0] cmd_data,
    input wire clock
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        cmd_addr = 24'h000000;
        cmd_data = 16'h0000;
    end
    // Lane pins are always driven by the bench, never tied
    task send(input [7:0] c, input [23:0] a, input [15:0] d);
        begin
            @(negedge clock);
            cmd_valid = 1'b1;
            cmd_code = c;
            cmd_addr = a;
            cmd_data = d;
            @(negedge clock);
            cmd_valid = 1'b0;
            // Released lines carry no stale value
            cmd_code = ~c;
            cmd_addr = ~a;
            cmd_data = ~d;
        end
    endtask
endmodule // sfwp_host

// ==== sim/tb_sfwp_top.sv ====
// Self-checking testbench for the write protection block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((e) !== (g)) begin n_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_sfwp_top;
    reg clock = 1'b0;
    reg nrst = 1'b0;
    reg power_cycle = 1'b0;
    reg wp_n = 1'b1;
    reg hold_n = 1'b1;
    wire cmd_valid, cmd_done, cmd_refused, cmd_ignored, op_start, quad_lane_enable;
    wire hold_active, deep_pd;
    wire [7:0] cmd_code, op_code;
    wire [23:0] cmd_addr, op_addr;
    wire [15:0] cmd_data, status_out;
    integer n_errors = 0;
    integer checks_done = 0;
    integer v, k;
    reg [15:0] st = 16'h0000;
    reg dpd = 1'b0, arm = 1'b0, hw = 1'b0;
    reg [31:0] rnd, pick;
    always #50 clock = ~clock;
    sfwp_top i_sfwp_top (.clock(clock), .nrst(nrst), .power_cycle(power_cycle),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .wp_n(wp_n), .hold_n(hold_n), .status_out(status_out), .cmd_done(cmd_done),
        .cmd_refused(cmd_refused), .cmd_ignored(cmd_ignored), .op_start(op_start),
        .op_code(op_code), .op_addr(op_addr), .quad_lane_enable(quad_lane_enable),
        .hold_active(hold_active), .deep_pd(deep_pd));
    sfwp_host i_sfwp_host (.clock(clock), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data));
    function prot(input [23:0] a);
        integer bp, sz;
        begin
            bp = st[4:2];
            sz = st[6] ? 1 << (11 + (bp > 4 ? 4 : bp)) : 1 << (17 + bp);
            prot = st[14] ^ (bp == 7 || (bp != 0 && (st[5] ? a < sz : a >= 32'h1000000 - sz)));
        end
    endfunction
    task end_sim;
        begin
            $display("Checks %0d, errors %0d", checks_done, n_errors);
            if (n_errors == 0 && checks_done > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    task run(input [7:0] c, input [23:0] a, input [15:0] d);
        reg [2:0] r;
        reg go;
        reg [23:0] sp;
        begin
            pick = $urandom;
            hold_n = pick[0];
            r = 3'b001;
            go = 1'b0;
            sp = 24'h000000;
            if (st[8:7] == 2'h1 && !(wp_n || st[9])) hw = 1'b1;
            if (dpd && !(c == 8'hAB || c == 8'h66 || (c == 8'h99 && arm))) begin
                r = 3'b100;
            end else begin
                case (c)
                8'h06: st[1] = 1'b1;
                8'h04: st[1] = 1'b0;
                8'h01: if (st[1] && (st[8:7] == 2'h0 || (st[8:7] == 2'h1 && !hw)))
                    st = {1'b0, d[14], 1'b0, d[12], d[11:10] | st[11:10], d[9:2], 2'h0};
                else r = 3'b010;
                8'h20: sp = 24'h000FFF;
                8'h52: sp = 24'h007FFF;
                8'hD8: sp = 24'h00FFFF;
                8'h42: go = st[1] && !st[a[13] ? 11 : 10];
                8'h44: go = st[1] && st[11:10] == 2'h0;
                8'hB9: dpd = 1'b1;
                8'hAB: dpd = 1'b0;
                8'h99: if (arm) {dpd, st[1]} = 2'b00;
                default: ;
                endcase
                if (c inside {8'h02, 8'h20, 8'h52, 8'hD8})
                    go = st[1] && !st[12] && !prot(a & ~sp) && !prot(a | sp);
                if (c inside {8'hC7, 8'h60}) go = st[1] && !st[12] && st[4:2] == {3{st[14]}};
                if (c inside {8'h01, 8'h02, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h42, 8'h44}) begin
                    st[1] = 1'b0;
                    if (c != 8'h01) r = go ? 3'b001 : 3'b010;
                end
            end
            // Any command taken but 66 disarms a pending reset
            arm = c == 8'h66;
            i_sfwp_host.send(c, a, d);
            `CHK("answer", r, {cmd_ignored, cmd_refused, cmd_done})
            `CHK("launch", go, op_start)
            if (go) `CHK("op code", c, op_code)
            if (go && c == 8'h02) `CHK("op addr", a, op_addr)
            @(negedge clock);
            `CHK("status", st, status_out)
            `CHK("quad", st[9], quad_lane_enable)
            `CHK("hold", !hold_n && !st[9], hold_active)
            `CHK("deep pd", dpd, deep_pd)
        end
    endtask
    task wr(input [15:0] d);
        begin
            run(8'h06, 24'h000000, 16'h0000);
            run(8'h01, 24'h000000, d);
        end
    endtask
    task pwr;
        begin
            power_cycle = 1'b1;
            @(negedge clock);
            power_cycle = 1'b0;
            {st[1], dpd, arm, hw} = 4'h0;
            if (st[8:7] == 2'h2) st[8:7] = 2'h0;
            @(negedge clock);
            `CHK("power cycle", st, status_out)
        end
    endtask
    initial begin
        rnd = $urandom(32'h659f);
        repeat (8) @(negedge clock);
        nrst = 1'b1;
        `CHK("reset status", 16'h0000, status_out)
        run(8'h06, 24'h000000, 16'h0000);
        run(8'h02, 24'h000000, 16'h0000);
        run(8'h01, 24'h000000, 16'h0004);
        for (v = 0; v < 64; v++) begin
            wr({1'b0, v[5], 7'h00, v[4:0], 2'h0});
            for (k = 0; k < 6; k++) begin
                rnd = $urandom;
                run(8'h06, 24'h000000, 16'h0000);
                case (k)
                0: run(8'h02, rnd[23:0], 16'h0000);
                1: run(8'h02, 24'hFFFFFF, 16'h0000);
                2: run(8'h20, rnd[23:0] & 24'hFFF000, 16'h0000);
                3: run(8'h52, rnd[23:0] & 24'hFF8000, 16'h0000);
                4: run(8'hD8, rnd[23:0] & 24'hFF0000, 16'h0000);
                default: run(v[5] ? 8'h60 : 8'hC7, 24'h000000, 16'h0000);
                endcase
            end
        end
        wr(16'h1000);
        run(8'h06, 24'h000000, 16'h0000);
        run(8'h02, 24'h123400, 16'h0000);
        wr(16'h0200);
        wr(16'h0000);
        wr(16'h0400);
        wr(16'h0000);
        for (k = 0; k < 3; k++) begin
            run(8'h06, 24'h000000, 16'h0000);
            run(k == 2 ? 8'h44 : 8'h42, k == 1 ? 24'h002000 : 24'h001000, 16'h0000);
        end
        run(8'hB9, 24'h000000, 16'h0000);
        run(8'h99, 24'h000000, 16'h0000);
        run(8'h06, 24'h000000, 16'h0000);
        run(8'h66, 24'h000000, 16'h0000);
        run(8'h99, 24'h000000, 16'h0000);
        run(8'hB9, 24'h000000, 16'h0000);
        run(8'hAB, 24'h000000, 16'h0000);
        run(8'h66, 24'h000000, 16'h0000);
        run(8'h06, 24'h000000, 16'h0000);
        run(8'h99, 24'h000000, 16'h0000);
        run(8'h66, 24'h000000, 16'h0000);
        run(8'h99, 24'h000000, 16'h0000);
        wr(16'h0080);
        wr(16'h0084);
        wp_n = 1'b0;
        wr(16'h0080);
        wp_n = 1'b1;
        wr(16'h0080);
        pwr;
        wr(16'h0100);
        wr(16'h0000);
        pwr;
        wr(16'h0180);
        wr(16'h0000);
        pwr;
        wr(16'h0000);
        end_sim;
    end
    // About five times the expected run length
    initial begin
        #1500000;
        n_errors++;
        end_sim;
    end
endmodule // tb_sfwp_top
